// *** rtl/aisc_pkg.sv ***
// Package of constants and types for the analog input scaling curve block
package aisc_pkg;
   // ==========================================
   // Data format: signed fixed point, 1 LSB = 0.00001
   localparam int DATA_W          = 40;
   localparam int FRAC_SCALE      = 100000;
   localparam int NUM_SRC         = 3;
   localparam int SEL_W           = 2;
   localparam int MAX_POINTS      = 20;
   localparam int PT_IDX_W        = 5;
   localparam int COEF_W          = 16;

   // ==========================================
   // Timing: clock, update cycle, filter time constant
   localparam int CLK_MHZ         = 250;
   localparam int CYCLE_STEP_MS   = 5;
   localparam int CYCLE_DEF_MS    = 150;
   localparam int CYCLE_STEP_CLKS = CYCLE_STEP_MS * CLK_MHZ * 1000;
   localparam int TAU_STEP_MS     = 5;
   localparam int TAU_DEF_STEPS   = 200;
   localparam int CYCLE_DEF_STEPS = CYCLE_DEF_MS / CYCLE_STEP_MS;

   // ==========================================
   // Reset values of settings
   localparam logic [SEL_W-1:0] SEL_RST = 2'h0;

   // ==========================================
   // Source selector codes
   typedef enum logic [1:0]
   {
      AISC_SRC_MA   = 2'b00,
      AISC_SRC_DIV  = 2'b01,
      AISC_SRC_RES  = 2'b10
   } aisc_src_t;

   // Output handling modes
   typedef enum logic [1:0]
   {
      AISC_RND_FLOAT   = 2'b00,
      AISC_RND_FLOOR   = 2'b01,
      AISC_RND_CEIL    = 2'b10,
      AISC_RND_NEAREST = 2'b11
   } aisc_round_t;

   // Sequencer states
   typedef enum logic [2:0]
   {
      AISC_ST_IDLE   = 3'b000,
      AISC_ST_FILT   = 3'b001,
      AISC_ST_SEARCH = 3'b010,
      AISC_ST_INTERP = 3'b011,
      AISC_ST_DONE   = 3'b100
   } aisc_state_t;
endpackage

// *** rtl/aisc_interp.sv ***
// Sequential divider used for straight-line interpolation between two points
`timescale 1ns/1ps
module aisc_interp
   import aisc_pkg::*;
#(
   parameter int W = DATA_W
)
(
   input  wire logic                core_clk,
   input  wire logic                nrst,
   input  wire logic                ce,
   input  wire logic                start,
   input  wire logic signed [W-1:0] x,
   input  wire logic signed [W-1:0] x0,
   input  wire logic signed [W-1:0] x1,
   input  wire logic signed [W-1:0] y0,
   input  wire logic signed [W-1:0] y1,
   output logic                     busy,
   output logic                     done,
   output logic signed [W-1:0]      y
);
   // ==========================================
   // Working registers
   logic        [2*W-1:0] num;
   logic        [W-1:0]   den;
   logic        [2*W-1:0] rem;
   logic        [2*W-1:0] quo;
   logic                  neg;
   logic        [6:0]     cnt;
   logic signed [W-1:0]   base;

   // Magnitude of a signed value
   function automatic logic [2*W-1:0] mag2(input logic signed [2*W-1:0] v);
      mag2 = v[2*W-1] ? (2*W)'(-v) : v;
   endfunction

   // Restoring division, one quotient bit per cycle; slow but small area
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy <= 1'b0;
         done <= 1'b0;
         num  <= '0;
         den  <= '0;
         rem  <= '0;
         quo  <= '0;
         neg  <= 1'b0;
         cnt  <= 7'h00;
         base <= '0;
         y    <= '0;
      end
      else if (ce)
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            logic signed [2*W-1:0] prod;
            logic signed [W-1:0]   dx;
            logic        [2*W-1:0] dmag;
            prod = (2*W)'(signed'(x - x0)) * (2*W)'(signed'(y1 - y0));
            dx   = x1 - x0;
            dmag = mag2((2*W)'(dx));
            neg  <= prod[2*W-1] ^ dx[W-1];
            num  <= mag2(prod);
            den  <= dmag[W-1:0];
            rem  <= '0;
            quo  <= '0;
            base <= y0;
            cnt  <= 7'((2*W));
            busy <= 1'b1;
         end
         else if (busy)
         begin
            logic [2*W-1:0] r;
            r = {rem[2*W-2:0], num[2*W-1]};
            num <= {num[2*W-2:0], 1'b0};
            if (r >= (2*W)'(den))
            begin
               rem <= r - (2*W)'(den);
               quo <= {quo[2*W-2:0], 1'b1};
            end
            else
            begin
               rem <= r;
               quo <= {quo[2*W-2:0], 1'b0};
            end
            cnt <= cnt - 7'h01;
            if (cnt == 7'h01)
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
         if (done)
         begin
            // Sign applied one clock after the last quotient bit; zero span gives the first point
            y <= (den == '0) ? base
                 : base + (neg ? -W'(quo) : W'(quo));
         end
      end
   end
endmodule

// *** rtl/aisc_curve.sv ***
// Analog input scaling curve: source select, filter, limits and curve mapping
// Function
// - Channel master enable, reset disabled; no scaled result while disabled.
// - Curve enable, reset disabled; clearing stops measurement and computation.
// - Selector picks milliampere, input voltage or resistance; resets to milliampere.
// - Optional filtering replaces raw input by running average before limits.
// - Filter time constant in 5 ms steps, default 1 s, used only when filtering.
// - Out-of-range output enabled per curve, default off; off keeps it low.
// - Lower limit, default 0; input below it flags out of range.
// - Upper limit, default 0; input above it flags out of range.
// - Received curve input after selection is presented as read-only output.
// - Scaled curve result is presented as read-only output.
// - Input recomputed once per update cycle, 5 ms steps, default 150 ms.
// - On lost input the last valid cycle value is held.
// - Linear two-point mapping, or up to 20 enabled user points.
// - Output kept fractional or rounded by floor, ceiling or nearest.
`timescale 1ns/1ps
module aisc_curve
   import aisc_pkg::*;
#(
   parameter int W          = DATA_W,
   parameter int NPTS       = MAX_POINTS,
   parameter int STEP_CLKS  = CYCLE_STEP_CLKS
)
(
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   input  wire logic                  ce,
   input  wire logic                  scaling_en,
   input  wire logic                  curve_en,
   input  wire logic [SEL_W-1:0]      src_sel,
   input  wire logic signed [W-1:0]   milliamp_input,
   input  wire logic                  milliamp_valid,
   input  wire logic signed [W-1:0]   digital_input_voltage,
   input  wire logic                  digital_input_voltage_valid,
   input  wire logic signed [W-1:0]   resistance_temperature_input,
   input  wire logic                  resistance_temperature_input_valid,
   input  wire logic                  filter_en,
   input  wire logic [19:0]           filter_tau_steps,
   input  wire logic [10:0]           update_cycle_steps,
   input  wire logic                  range_check_en,
   input  wire logic signed [W-1:0]   input_min,
   input  wire logic signed [W-1:0]   input_max,
   input  wire logic                  extra_points_en,
   input  wire logic [NPTS-1:0]       point_en,
   input  wire logic [NPTS*W-1:0]     point_x,
   input  wire logic [NPTS*W-1:0]     point_y,
   input  wire logic [1:0]            round_mode,
   output logic signed [W-1:0]        curve_input,
   output logic signed [W-1:0]        curve_output,
   output logic                       curve_output_valid,
   output logic                       analog_scaling_out_of_range
);
   // ==========================================
   // Helpers
   function automatic logic signed [W-1:0] pt(input logic [NPTS*W-1:0] v, input int i);
      pt = v[i*W +: W];
   endfunction

   // Rounding to a multiple of the fixed-point unit in the selected mode; float mode passes the value
   function automatic logic signed [W-1:0] round_val(input logic signed [W-1:0] v,
                                                     input logic [1:0] m);
      logic signed [W-1:0] q;
      logic signed [W-1:0] r;
      logic signed [W-1:0] u;
      u = W'(FRAC_SCALE);
      q = v / u;
      r = v - q * u;
      round_val = v;
      case (m)
         AISC_RND_FLOOR:   round_val = (r < 0) ? (q - 1) * u : q * u;
         AISC_RND_CEIL:    round_val = (r > 0) ? (q + 1) * u : q * u;
         AISC_RND_NEAREST: round_val = ((r >= u/2) ? q + 1 : (r <= -(u/2)) ? q - 1 : q) * u;
         default:          round_val = v;
      endcase
   endfunction

   // ==========================================
   // Update cycle timer
   logic [31:0] step_cnt;
   logic [10:0] cyc_cnt;
   logic        tick;
   logic        active;

   assign active = scaling_en && curve_en;

   // Counts 5 ms steps; a new cycle starts every update_cycle_steps steps
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         step_cnt <= 32'h0;
         cyc_cnt  <= 11'h0;
         tick     <= 1'b0;
      end
      else if (ce)
      begin
         tick <= 1'b0;
         if (!active)
         begin
            step_cnt <= 32'h0;
            cyc_cnt  <= 11'h0;
         end
         else if (step_cnt == 32'(STEP_CLKS - 1))
         begin
            step_cnt <= 32'h0;
            if (cyc_cnt + 11'h1 >= update_cycle_steps)
            begin
               cyc_cnt <= 11'h0;
               tick    <= 1'b1;
            end
            else
               cyc_cnt <= cyc_cnt + 11'h1;
         end
         else
            step_cnt <= step_cnt + 32'h1;
      end
   end

   // ==========================================
   // Source selection and hold of last valid value
   logic signed [W-1:0] sel_val;
   logic                sel_valid;
   logic signed [W-1:0] raw_hold;
   logic signed [W-1:0] filt;

   // Selector picks one measurement and its valid flag
   always_comb
   begin
      case (src_sel)
         AISC_SRC_DIV:
         begin
            sel_val   = digital_input_voltage;
            sel_valid = digital_input_voltage_valid;
         end
         AISC_SRC_RES:
         begin
            sel_val   = resistance_temperature_input;
            sel_valid = resistance_temperature_input_valid;
         end
         default:
         begin
            sel_val   = milliamp_input;
            sel_valid = milliamp_valid;
         end
      endcase
   end

   // ==========================================
   // Sequencer: filter, point search, interpolation
   aisc_state_t         state;
   logic [PT_IDX_W-1:0] idx;
   logic signed [W-1:0] sx0, sx1, sy0, sy1;
   logic signed [W-1:0] cur_x;
   logic                div_start;
   logic                div_busy;
   logic                div_done;
   logic signed [W-1:0] div_y;
   logic [COEF_W-1:0]   coef;

   // Coefficient = cycle / (tau + cycle + 1), as a fraction of 2^COEF_W
   assign coef = COEF_W'((32'(update_cycle_steps) << COEF_W) /
                         (32'(filter_tau_steps) + 32'(update_cycle_steps) + 32'h1));
   assign cur_x = filter_en ? filt : raw_hold;

   // Held input: updated only on a cycle with a valid sample
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         raw_hold <= '0;
      else if (ce && tick && sel_valid)
         raw_hold <= sel_val;
   end

   // Main sequencer; each step one cycle except the point search, one cycle per point, and the divider
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state     <= AISC_ST_IDLE;
         idx       <= '0;
         filt      <= '0;
         sx0       <= '0;
         sx1       <= '0;
         sy0       <= '0;
         sy1       <= '0;
         div_start <= 1'b0;
      end
      else if (ce)
      begin
         div_start <= 1'b0;
         case (state)
            AISC_ST_IDLE:
               if (tick && active)
                  state <= AISC_ST_FILT;
            AISC_ST_FILT:
            begin
               // Lost sample keeps the filter frozen as well
               if (filter_en && sel_valid)
                  filt <= filt + W'(((2*W)'(sel_val - filt) * (2*W)'(signed'({1'b0, coef})))
                                    >>> COEF_W);
               else if (!filter_en)
                  filt <= raw_hold;
               sx0   <= pt(point_x, 0);
               sy0   <= pt(point_y, 0);
               sx1   <= pt(point_x, 1);
               sy1   <= pt(point_y, 1);
               idx   <= PT_IDX_W'(2);
               state <= extra_points_en ? AISC_ST_SEARCH : AISC_ST_INTERP;
            end
            AISC_ST_SEARCH:
            begin
               // Walk enabled points until the input falls within a segment
               if (int'(idx) >= NPTS || !point_en[idx] || cur_x <= sx1)
               begin
                  state     <= AISC_ST_INTERP;
               end
               else
               begin
                  sx0 <= sx1;
                  sy0 <= sy1;
                  sx1 <= pt(point_x, int'(idx));
                  sy1 <= pt(point_y, int'(idx));
                  idx <= idx + PT_IDX_W'(1);
               end
            end
            AISC_ST_INTERP:
            begin
               if (!div_busy && !div_start && state == AISC_ST_INTERP && idx != '1)
               begin
                  div_start <= 1'b1;
                  idx       <= '1;
               end
               if (div_done)
                  state <= AISC_ST_DONE;
            end
            AISC_ST_DONE:
               state <= AISC_ST_IDLE;
            default:
               state <= AISC_ST_IDLE;
         endcase
         if (!active)
            state <= AISC_ST_IDLE;
      end
   end

   aisc_interp #(.W(W)) u_interp
   (
      .core_clk (core_clk),
      .nrst     (nrst),
      .ce       (ce),
      .start    (div_start),
      .x        (cur_x),
      .x0       (sx0),
      .x1       (sx1),
      .y0       (sy0),
      .y1       (sy1),
      .busy     (div_busy),
      .done     (div_done),
      .y        (div_y)
   );

   // ==========================================
   // Outputs: indications and out-of-range flag
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         curve_input                 <= '0;
         curve_output                <= '0;
         curve_output_valid          <= 1'b0;
         analog_scaling_out_of_range <= 1'b0;
      end
      else if (ce)
      begin
         if (!active)
         begin
            curve_output_valid          <= 1'b0;
            analog_scaling_out_of_range <= 1'b0;
         end
         else
         begin
            if (state == AISC_ST_DONE)
            begin
               curve_input        <= cur_x;
               curve_output       <= round_val(div_y, round_mode);
               curve_output_valid <= 1'b1;
            end
            analog_scaling_out_of_range <= range_check_en &&
                                           ((cur_x < input_min) || (cur_x > input_max));
         end
      end
   end
endmodule

// *** tb/aisc_curve_props.sv ***
// Port assertions for the analog input scaling curve
`timescale 1ns/1ps
module aisc_curve_props
   import aisc_pkg::*;
#(
   parameter int W = DATA_W
)
(
   input wire logic                core_clk,
   input wire logic                nrst,
   input wire logic                scaling_en,
   input wire logic                curve_en,
   input wire logic                filter_en,
   input wire logic                range_check_en,
   input wire logic signed [W-1:0] input_min,
   input wire logic signed [W-1:0] input_max,
   input wire logic signed [W-1:0] curve_input,
   input wire logic signed [W-1:0] curve_output,
   input wire logic                curve_output_valid,
   input wire logic                analog_scaling_out_of_range
);
   // ==========================================
   // Helpers
   logic                en;
   logic signed [W-1:0] prev_in;
   logic [7:0]          quiet;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // Both enables are needed before the channel does anything
   assign en = scaling_en & curve_en;

   // Clocks since curve_input moved; the internal sample may lead it, so judge only after
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prev_in <= '0;
         quiet   <= 8'h00;
      end
      else
      begin
         prev_in <= curve_input;
         if (curve_input != prev_in)
            quiet <= 8'h00;
         else if (quiet != 8'hff)
            quiet <= quiet + 8'h01;
      end
   end

   // ==========================================
   // Properties
   sequence s_calm;
      (en && range_check_en && !filter_en && $stable(input_min) && $stable(input_max)) [*2]
         ##0 (quiet >= 8'h02 && quiet <= 8'h28);
   endsequence

   a_valid_off: assert property (!en |=> !curve_output_valid)
      else $error("valid while disabled");
   a_flag_off: assert property (!en |=> !analog_scaling_out_of_range)
      else $error("range flag while disabled");
   a_flag_gated: assert property (!range_check_en |=> !analog_scaling_out_of_range)
      else $error("range flag while check off");
   a_first_result: assert property ($rose(en) |-> ##[1:1000] (curve_output_valid || !en))
      else $error("no result after enable");
   a_valid_holds: assert property (curve_output_valid && en |=> curve_output_valid)
      else $error("valid dropped while enabled");
   a_out_steady: assert property
      (en && $changed(curve_output) |=> ($stable(curve_output) || !en) [*8])
      else $error("output changed twice in quick order");
   a_below_min: assert property
      (s_calm ##0 (curve_input < input_min) |-> analog_scaling_out_of_range)
      else $error("no range flag below minimum");
   a_above_max: assert property
      (s_calm ##0 (curve_input > input_max) |-> analog_scaling_out_of_range)
      else $error("no range flag above maximum");
endmodule

bind aisc_curve aisc_curve_props #(.W(W)) u_props
(
   .core_clk, .nrst, .scaling_en, .curve_en, .filter_en, .range_check_en,
   .input_min, .input_max, .curve_input, .curve_output, .curve_output_valid,
   .analog_scaling_out_of_range
);

// *** tb/testbench.sv ***
// Self-checking bench for the analog input scaling curve
`timescale 1ns/1ps
module testbench
   import aisc_pkg::*;
;
   localparam int U = FRAC_SCALE;

   logic                         core_clk = 1'b0;
   logic                         nrst, ce, scaling_en, curve_en, filter_en;
   logic                         ma_v, dv_v, rt_v, range_check_en, extra_points_en;
   logic [SEL_W-1:0]             src_sel;
   logic [1:0]                   round_mode;
   logic [19:0]                  tau;
   logic [10:0]                  cyc;
   logic [MAX_POINTS-1:0]        point_en;
   logic [MAX_POINTS*DATA_W-1:0] point_x, point_y;
   logic signed [DATA_W-1:0]     ma, dv, rt, input_min, input_max, curve_input, curve_output;
   logic                         valid, oor;
   int                           fail_count = 0;
   int                           samples_checked = 0;
   longint                       exp_v [4];

   // Core clock, 4 ns period
   always #2 core_clk = ~core_clk;

   // Step of 10 clocks keeps an update cycle short: 20 steps = 200 clocks
   aisc_curve #(.STEP_CLKS(10)) dut_u
   (
      .core_clk, .nrst, .ce, .scaling_en, .curve_en, .src_sel,
      .milliamp_input(ma), .milliamp_valid(ma_v),
      .digital_input_voltage(dv), .digital_input_voltage_valid(dv_v),
      .resistance_temperature_input(rt), .resistance_temperature_input_valid(rt_v),
      .filter_en, .filter_tau_steps(tau), .update_cycle_steps(cyc), .range_check_en,
      .input_min, .input_max, .extra_points_en, .point_en, .point_x, .point_y,
      .round_mode, .curve_input, .curve_output, .curve_output_valid(valid),
      .analog_scaling_out_of_range(oor)
   );

   // ==========================================
   // Tasks
   // Waits past the edge so registered outputs have landed before sampling
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic chk_val(input string n, input longint e, input logic signed [DATA_W-1:0] g);
      samples_checked++;
      if (g !== DATA_W'(e))
      begin
         fail_count++;
         $display("[ERR] %s expected %0d seen %0d", n, e, g);
      end
   endtask

   task automatic chk_bit(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ==========================================
   // Tests; curve points (0,0) (10,100) (20,300) in whole units
   initial
   begin
      nrst = 1'b0;
      {scaling_en, curve_en, filter_en, range_check_en, extra_points_en} = 5'h00;
      {ce, ma_v, dv_v, rt_v} = 4'hf;
      {src_sel, round_mode, tau, cyc} = {2'h0, 2'h0, 20'h00014, 11'h014};
      {ma, dv, rt} = {DATA_W'(0), DATA_W'(U), DATA_W'(2 * U)};
      {input_min, input_max} = '0;
      point_en = 20'h00007;
      point_x = '0;
      point_y = '0;
      point_x[DATA_W+:DATA_W] = DATA_W'(10 * U);
      point_y[DATA_W+:DATA_W] = DATA_W'(100 * U);
      point_x[2*DATA_W+:DATA_W] = DATA_W'(20 * U);
      point_y[2*DATA_W+:DATA_W] = DATA_W'(300 * U);
      exp_v = '{51 * U / 2, 25 * U, 26 * U, 26 * U};
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      settle(2);
      chk_bit("valid after reset", 1'b0, valid);
      // One enable at a time must give nothing
      @(posedge core_clk);
      {scaling_en, ma} <= {1'b1, DATA_W'(5 * U / 2)};
      settle(450);
      chk_bit("valid, curve off", 1'b0, valid);
      @(posedge core_clk);
      {scaling_en, curve_en} <= 2'b01;
      settle(450);
      chk_bit("valid, channel off", 1'b0, valid);
      @(posedge core_clk);
      scaling_en <= 1'b1;
      settle(450);
      chk_bit("valid", 1'b1, valid);
      chk_val("input", 5 * U / 2, curve_input);
      chk_val("output", 25 * U, curve_output);
      // Every selector code; code 3 falls back to the milliampere source
      for (int s = 1; s < 4; s++)
      begin
         @(posedge core_clk);
         src_sel <= SEL_W'(s);
         settle(450);
         chk_val("selected input", (s == 3) ? 5 * U / 2 : s * U, curve_input);
      end
      @(posedge core_clk);
      {src_sel, ma_v, ma} <= {2'h0, 1'b0, DATA_W'(7 * U)};
      settle(450);
      chk_val("held input", 5 * U / 2, curve_input);
      // Each handling mode on an output halfway between whole units
      @(posedge core_clk);
      {ma_v, ma} <= {1'b1, DATA_W'(51 * U / 20)};
      for (int m = 0; m < 4; m++)
      begin
         @(posedge core_clk);
         round_mode <= 2'(m);
         settle(450);
         chk_val("rounded output", exp_v[m], curve_output);
      end
      @(posedge core_clk);
      {round_mode, input_min, input_max} <= {2'h0, DATA_W'(U), DATA_W'(5 * U)};
      ma <= DATA_W'(7 * U);
      settle(450);
      chk_bit("range flag, check off", 1'b0, oor);
      for (int k = 0; k < 3; k++)
      begin
         @(posedge core_clk);
         range_check_en <= 1'b1;
         ma <= DATA_W'((k == 0) ? 5 * U / 2 : ((k == 1) ? 7 * U : U / 2));
         settle(450);
         chk_bit("range flag", k != 0, oor);
      end
      @(posedge core_clk);
      {range_check_en, ma} <= {1'b0, DATA_W'(15 * U)};
      settle(450);
      chk_val("two-point output", 150 * U, curve_output);
      @(posedge core_clk);
      extra_points_en <= 1'b1;
      settle(450);
      chk_val("multi-point output", 200 * U, curve_output);
      // Step into the filter from rest; raw input sits above the upper limit
      @(posedge core_clk);
      {extra_points_en, ma} <= {1'b0, DATA_W'(0)};
      settle(450);
      @(posedge core_clk);
      {filter_en, range_check_en, input_min} <= {2'b11, DATA_W'(0)};
      {input_max, ma} <= {DATA_W'(9 * U), DATA_W'(10 * U)};
      settle(450);
      chk_bit("input filtered", 1'b1, curve_input > 0 && curve_input < 9 * U);
      chk_bit("range flag on filtered", 1'b0, oor);
      settle(6000);
      chk_bit("input settled", 1'b1, curve_input > 10 * U - 100 && curve_input <= 10 * U);
      chk_bit("range flag settled", 1'b1, oor);
      // Clock enable low must freeze filter state and outputs while the input drops
      @(posedge core_clk);
      {ce, ma} <= {1'b0, DATA_W'(0)};
      settle(450);
      chk_bit("input frozen", 1'b1, curve_input > 10 * U - 100);
      chk_bit("range flag frozen", 1'b1, oor);
      chk_bit("valid frozen", 1'b1, valid);
      @(posedge core_clk);
      ce <= 1'b1;
      @(posedge core_clk);
      scaling_en <= 1'b0;
      settle(2);
      chk_bit("valid after disable", 1'b0, valid);
      chk_bit("range flag after disable", 1'b0, oor);
      wrap_up;
   end

   // Watchdog: the tests need about 60 us
   initial
   begin
      #150us;
      fail_count++;
      $display("[ERR] watchdog expected finish seen hang");
      wrap_up;
   end
endmodule
